/* core/tpc_pkg.sv */
package tpc_pkg;

   // ****************************************
   // Codes and constants
   // ****************************************
   localparam logic [1:0] CLK_OFF = 2'h0;
   localparam logic [1:0] CLK_BUS = 2'h1;
   localparam logic [1:0] CLK_FIXED = 2'h2;
   localparam logic [1:0] CLK_EXT = 2'h3;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam int SIGN_BIT = 15;

   typedef enum {MODE_CAPTURE, MODE_COMPARE, MODE_EDGE_PWM, MODE_CENTER_PWM} tpc_mode_t;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic modeSelB;
      logic modeSelA;
      logic edgeLevelSelectB;
      logic edgeLevelSelectA;
      logic channelIrqEnable;
   } tpc_chan_cfg_t;

   typedef struct packed {
      logic [7:0] data;
      logic high;
      logic low;
   } tpc_byte_wr_t;

   typedef struct packed {
      logic tick;
      logic wrap;
      logic reverse;
      logic stepDown;
      logic loadDue;
      logic [15:0] count;
      logic [15:0] nextCount;
      logic [15:0] modulus;
   } tpc_timebase_t;

   // ****************************************
   // State records and their reset values
   // ****************************************
   typedef struct packed {
      logic [15:0] count;
      logic countDown;
      logic [15:0] modulus;
      logic [15:0] modBuf;
      logic modHiSeen;
      logic modLoSeen;
      logic overflowFlag;
      logic overflowArmed;
      logic [15:0] countLatch;
      logic latched;
      logic firstHigh;
      logic [7:0] countByte;
   } tpc_timer_state_t;

   typedef struct packed {
      logic [15:0] value;
      logic [15:0] buffer;
      logic hiSeen;
      logic loSeen;
      logic pinOut;
      logic pinOe;
      logic pinPrev;
      logic flag;
      logic armed;
   } tpc_chan_state_t;

   localparam tpc_timer_state_t TIMER_RESET = '0;
   localparam tpc_chan_state_t CHAN_RESET = '0;

   function automatic tpc_mode_t decodeMode(input logic center_aligned_pwm, input tpc_chan_cfg_t c);
      if (center_aligned_pwm)
         return MODE_CENTER_PWM;
      else if (c.modeSelB)
         return MODE_EDGE_PWM;
      else if (c.modeSelA)
         return MODE_COMPARE;
      else
         return MODE_CAPTURE;
   endfunction

endpackage

/* core/tpc_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module tpc_channel (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Time base and configuration.
   input wire tpc_pkg::tpc_timebase_t timeBase,
   input wire logic centerAlignSelect,
   input wire tpc_pkg::tpc_chan_cfg_t cfg,
   // Software access.
   input wire logic ctrlWrite,
   input wire tpc_pkg::tpc_byte_wr_t valueWrite,
   input wire logic flagRead,
   input wire logic flagClear,
   // Pin.
   input wire logic pinIn,
   output logic pinOut,
   output logic pinOe,
   // Status.
   output logic [15:0] value,
   output logic channelFlag,
   output logic channelIrq
);
   tpc_pkg::tpc_chan_state_t st_r, st_nxt;
   tpc_pkg::tpc_mode_t mode;
   logic match, activeLevel, valueDead, edgeSeen, chanEvent, bufFull;

   assign mode = tpc_pkg::decodeMode(centerAlignSelect, cfg);

   always_comb
   begin
      st_nxt = st_r;
      // Compares look at the count being entered, so the pin flips as the counter arrives.
      match = timeBase.tick && timeBase.nextCount == st_r.value;
      activeLevel = !cfg.edgeLevelSelectA;
      valueDead = st_r.value == tpc_pkg::COUNT_ZERO || st_r.value[tpc_pkg::SIGN_BIT];
      edgeSeen = (cfg.edgeLevelSelectA && pinIn && !st_r.pinPrev)
         || (cfg.edgeLevelSelectB && !pinIn && st_r.pinPrev);
      bufFull = st_r.hiSeen && st_r.loSeen;
      chanEvent = 1'b0;
      st_nxt.pinPrev = pinIn;
      st_nxt.pinOe = mode != tpc_pkg::MODE_CAPTURE
         && !(mode == tpc_pkg::MODE_COMPARE && !cfg.edgeLevelSelectA && !cfg.edgeLevelSelectB);
      unique case (mode)
         tpc_pkg::MODE_CAPTURE, tpc_pkg::MODE_COMPARE:
         begin
            if (bufFull)
               st_nxt.value = st_r.buffer;
            if (mode == tpc_pkg::MODE_CAPTURE && edgeSeen)
            begin
               st_nxt.value = timeBase.count;
               chanEvent = 1'b1;
            end
            if (mode == tpc_pkg::MODE_COMPARE && match)
            begin
               chanEvent = 1'b1;
               if (cfg.edgeLevelSelectA && cfg.edgeLevelSelectB)
                  st_nxt.pinOut = 1'b1;
               else if (cfg.edgeLevelSelectB)
                  st_nxt.pinOut = 1'b0;
               else if (cfg.edgeLevelSelectA)
                  st_nxt.pinOut = !st_r.pinOut;
            end
         end
         tpc_pkg::MODE_EDGE_PWM:
         begin
            if (bufFull && timeBase.loadDue)
               st_nxt.value = st_r.buffer;
            if (timeBase.wrap)
               st_nxt.pinOut = activeLevel;
            if (match)
            begin
               st_nxt.pinOut = !activeLevel;
               chanEvent = 1'b1;
            end
         end
         tpc_pkg::MODE_CENTER_PWM:
         begin
            if (bufFull && timeBase.loadDue)
               st_nxt.value = st_r.buffer;
            if (match)
            begin
               st_nxt.pinOut = timeBase.stepDown ? activeLevel : !activeLevel;
               chanEvent = 1'b1;
            end
            if (timeBase.tick && valueDead)
               st_nxt.pinOut = !activeLevel;
            else if (timeBase.tick && st_r.value > timeBase.modulus)
               st_nxt.pinOut = activeLevel;
         end
      endcase
      if ((bufFull && mode inside {tpc_pkg::MODE_CAPTURE, tpc_pkg::MODE_COMPARE})
         || (bufFull && timeBase.loadDue))
      begin
         st_nxt.hiSeen = 1'b0;
         st_nxt.loSeen = 1'b0;
      end
      if (valueWrite.high)
      begin
         st_nxt.buffer[15:8] = valueWrite.data;
         st_nxt.hiSeen = 1'b1;
      end
      if (valueWrite.low)
      begin
         st_nxt.buffer[7:0] = valueWrite.data;
         st_nxt.loSeen = 1'b1;
      end
      if (ctrlWrite)
      begin
         st_nxt.hiSeen = 1'b0;
         st_nxt.loSeen = 1'b0;
      end
      // A new event outranks a pending clear so that it is never lost.
      if (chanEvent)
      begin
         st_nxt.flag = 1'b1;
         st_nxt.armed = 1'b0;
      end
      else if (flagClear && st_r.armed)
      begin
         st_nxt.flag = 1'b0;
         st_nxt.armed = 1'b0;
      end
      else if (flagRead && st_r.flag)
         st_nxt.armed = 1'b1;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
         st_r <= tpc_pkg::CHAN_RESET;
      else
         st_r <= st_nxt;
   end

   assign pinOut = st_r.pinOut;
   assign pinOe = st_r.pinOe;
   assign value = st_r.value;
   assign channelFlag = st_r.flag;
   assign channelIrq = st_r.flag && cfg.channelIrqEnable;

   default clocking cbc @(posedge clock);
   endclocking
   default disable iff (reset);

   property p_chanMatchFlag;
      match && mode != tpc_pkg::MODE_CAPTURE |=> st_r.flag;
   endproperty
   a_chanMatchFlag: assert property (p_chanMatchFlag) else $error("match did not flag");

   property p_edgeLowAtWrap;
      mode == tpc_pkg::MODE_EDGE_PWM && timeBase.wrap && cfg.edgeLevelSelectA && !match
         |=> !pinOut;
   endproperty
   a_edgeLowAtWrap: assert property (p_edgeLowAtWrap) else $error("pin not low at wrap");

   property p_centerUpMatch;
      mode == tpc_pkg::MODE_CENTER_PWM && match && !timeBase.stepDown && !valueDead
         && !cfg.edgeLevelSelectA && st_r.value <= timeBase.modulus |=> !pinOut;
   endproperty
   a_centerUpMatch: assert property (p_centerUpMatch) else $error("up match not low");

   property p_deadValue;
      mode == tpc_pkg::MODE_CENTER_PWM && timeBase.tick && valueDead
         |=> pinOut == $past(cfg.edgeLevelSelectA);
   endproperty
   a_deadValue: assert property (p_deadValue) else $error("dead value not idle");

   property p_edgeLoadAtWrap;
      mode == tpc_pkg::MODE_EDGE_PWM && !$stable(st_r.value) |-> $past(timeBase.loadDue);
   endproperty
   a_edgeLoadAtWrap: assert property (p_edgeLoadAtWrap) else $error("value loaded off wrap");

   c_centerPulse: cover property (mode == tpc_pkg::MODE_CENTER_PWM && pinOut ##[1:40] !pinOut);
endmodule
`default_nettype wire

/* core/tpc_timer_pwm_channel_unit.sv */
// Function
// - Edge PWM uses plain up-count; other channels may capture or compare meanwhile.
// - Edge PWM: modulus sets period, channel value sets duty from overflow.
// - Edge PWM with polarity set: low at overflow, high at compare.
// - Edge PWM: value zero gives 0%, value above modulus gives 100%.
// - Edge PWM value bytes buffered, loaded when both written and count reaches zero.
// - Center PWM counts up zero to modulus and back; period twice modulus.
// - Center PWM active pulse lasts twice the channel value in timer ticks.
// - Center PWM: zero or negative value gives 0%; value above modulus 100%.
// - Center PWM polarity clear: up match drives low, down match drives high.
// - Center PWM modulus and value buffered, loaded at reversal; compare exempt.
// - Control writes discard pending modulus or channel value bytes.
// - Each flag with its enable set gives a level interrupt.
// - Flag clears by read while set then zero write; new event keeps it.
// - Up-count overflow flag sets on wrap from terminal count to zero.
// - Up/down overflow flag sets when counter turns down from modulus.
// - Capture edge select picks rising, falling, both or off; edge sets flag.
// - Output compare flag sets whenever a timer tick brings the counter to the channel value.
// - Edge PWM flag sets at compare match ending the active portion.
// - Center PWM flag sets at both compare matches of each cycle.
// - Modulus zero in up-count lets counter run through 0xffff.
// - After reset clock source is off; others are bus, fixed, external.
// - Writing either count byte clears counter and read coherency buffer.
`timescale 1ns/1ps
`default_nettype none
module tpc_timer_pwm_channel_unit #(
   parameter int CHANNELS = 2
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Timer configuration.
   input wire logic [1:0] clockSourceSelect,
   input wire logic centerAlignSelect,
   input wire logic overflowIrqEnable,
   input wire logic fixedClockTick,
   input wire logic externalClockTick,
   // Timer register access.
   input wire logic timerControlWrite,
   input wire tpc_pkg::tpc_byte_wr_t modulusWrite,
   input wire logic countWrite,
   input wire logic countReadHigh,
   input wire logic countReadLow,
   input wire logic overflowFlagRead,
   input wire logic overflowFlagClear,
   // Channel register access.
   input wire tpc_pkg::tpc_chan_cfg_t [CHANNELS-1:0] chanCfg,
   input wire logic [CHANNELS-1:0] chanControlWrite,
   input wire tpc_pkg::tpc_byte_wr_t [CHANNELS-1:0] chanValueWrite,
   input wire logic [CHANNELS-1:0] chanFlagRead,
   input wire logic [CHANNELS-1:0] chanFlagClear,
   // Channel pins.
   input wire logic [CHANNELS-1:0] chanPinIn,
   output logic [CHANNELS-1:0] chanPinOut,
   output logic [CHANNELS-1:0] chanPinOe,
   // Timer status.
   output logic [15:0] count,
   output logic [15:0] modulus,
   output logic [7:0] countReadByte,
   output logic overflowFlag,
   output logic overflowIrq,
   // Channel status.
   output logic [CHANNELS-1:0][15:0] chanValue,
   output logic [CHANNELS-1:0] chanFlag,
   output logic [CHANNELS-1:0] chanIrq
);

   // ****************************************
   // Parameter check
   // ****************************************
   if (CHANNELS < 1)
   begin : gCheck
      $error("CHANNELS must be at least one");
   end

   tpc_pkg::tpc_timer_state_t st_r, st_nxt;
   tpc_pkg::tpc_timebase_t timeBase;
   logic tick;
   logic [15:0] terminal;
   logic [15:0] readSource;
   logic readAny;

   // ****************************************
   // Counter, modulus and overflow flag
   // ****************************************
   always_comb
   begin
      st_nxt = st_r;
      // The clock source gate: off after reset, so nothing counts until chosen.
      unique case (clockSourceSelect)
         tpc_pkg::CLK_OFF: tick = 1'b0;
         tpc_pkg::CLK_BUS: tick = 1'b1;
         tpc_pkg::CLK_FIXED: tick = fixedClockTick;
         tpc_pkg::CLK_EXT: tick = externalClockTick;
      endcase
      // A count write in the same cycle outranks the tick.
      tick = tick && !countWrite;
      terminal = st_r.modulus == tpc_pkg::COUNT_ZERO ? tpc_pkg::COUNT_MAX : st_r.modulus;
      timeBase = '0;
      timeBase.tick = tick;
      timeBase.count = st_r.count;
      timeBase.modulus = st_r.modulus;
      if (centerAlignSelect)
      begin
         if (!st_r.countDown)
         begin
            if (st_r.count == st_r.modulus && st_r.modulus != tpc_pkg::COUNT_ZERO)
            begin
               timeBase.nextCount = st_r.count - tpc_pkg::COUNT_ONE;
               timeBase.stepDown = 1'b1;
               timeBase.reverse = tick;
            end
            else
               timeBase.nextCount = st_r.count + tpc_pkg::COUNT_ONE;
         end
         else if (st_r.count == tpc_pkg::COUNT_ZERO)
            timeBase.nextCount = tpc_pkg::COUNT_ONE;
         else
         begin
            timeBase.nextCount = st_r.count - tpc_pkg::COUNT_ONE;
            timeBase.stepDown = 1'b1;
         end
      end
      else if (st_r.count == terminal)
      begin
         timeBase.nextCount = tpc_pkg::COUNT_ZERO;
         timeBase.wrap = tick;
      end
      else
         timeBase.nextCount = st_r.count + tpc_pkg::COUNT_ONE;
      // One load strobe serves the modulus and every PWM channel, so they change together.
      timeBase.loadDue = timeBase.wrap || timeBase.reverse;

      if (countWrite)
      begin
         st_nxt.count = tpc_pkg::COUNT_ZERO;
         st_nxt.countDown = 1'b0;
      end
      else if (tick)
      begin
         st_nxt.count = timeBase.nextCount;
         st_nxt.countDown = timeBase.stepDown;
      end
      if (!centerAlignSelect)
         st_nxt.countDown = 1'b0;

      // Modulus bytes wait in the buffer until both are in and the period ends.
      if (st_r.modHiSeen && st_r.modLoSeen && timeBase.loadDue)
      begin
         st_nxt.modulus = st_r.modBuf;
         st_nxt.modHiSeen = 1'b0;
         st_nxt.modLoSeen = 1'b0;
      end
      if (modulusWrite.high)
      begin
         st_nxt.modBuf[15:8] = modulusWrite.data;
         st_nxt.modHiSeen = 1'b1;
      end
      if (modulusWrite.low)
      begin
         st_nxt.modBuf[7:0] = modulusWrite.data;
         st_nxt.modLoSeen = 1'b1;
      end
      if (timerControlWrite)
      begin
         st_nxt.modHiSeen = 1'b0;
         st_nxt.modLoSeen = 1'b0;
      end

      // An overflow in the clearing cycle keeps the flag set.
      if (timeBase.loadDue)
      begin
         st_nxt.overflowFlag = 1'b1;
         st_nxt.overflowArmed = 1'b0;
      end
      else if (overflowFlagClear && st_r.overflowArmed)
      begin
         st_nxt.overflowFlag = 1'b0;
         st_nxt.overflowArmed = 1'b0;
      end
      else if (overflowFlagRead && st_r.overflowFlag)
         st_nxt.overflowArmed = 1'b1;

      // ****************************************
      // Coherent count read
      // ****************************************
      // The first byte read freezes both; the other byte comes from that snapshot.
      readAny = countReadHigh || countReadLow;
      readSource = st_r.latched ? st_r.countLatch : st_r.count;
      if (readAny)
      begin
         st_nxt.countByte = countReadHigh ? readSource[15:8] : readSource[7:0];
         if (!st_r.latched)
         begin
            st_nxt.countLatch = st_r.count;
            st_nxt.latched = 1'b1;
            st_nxt.firstHigh = countReadHigh;
         end
         else if (countReadHigh != st_r.firstHigh)
            st_nxt.latched = 1'b0;
      end
      if (countWrite)
         st_nxt.latched = 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
         st_r <= tpc_pkg::TIMER_RESET;
      else
         st_r <= st_nxt;
   end

   assign count = st_r.count;
   assign modulus = st_r.modulus;
   assign countReadByte = st_r.countByte;
   assign overflowFlag = st_r.overflowFlag;
   assign overflowIrq = st_r.overflowFlag && overflowIrqEnable;

   // ****************************************
   // Channels
   // ****************************************
   for (genvar ch = 0; ch < CHANNELS; ch++)
   begin : gChan
      tpc_channel uChan (
         .clock(clock),
         .reset(reset),
         .timeBase(timeBase),
         .centerAlignSelect(centerAlignSelect),
         .cfg(chanCfg[ch]),
         .ctrlWrite(chanControlWrite[ch]),
         .valueWrite(chanValueWrite[ch]),
         .flagRead(chanFlagRead[ch]),
         .flagClear(chanFlagClear[ch]),
         .pinIn(chanPinIn[ch]),
         .pinOut(chanPinOut[ch]),
         .pinOe(chanPinOe[ch]),
         .value(chanValue[ch]),
         .channelFlag(chanFlag[ch]),
         .channelIrq(chanIrq[ch])
      );
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cbm @(posedge clock);
   endclocking
   default disable iff (reset);

   property p_upWrap;
      tick && !centerAlignSelect && st_r.count == terminal
         |=> st_r.count == tpc_pkg::COUNT_ZERO && st_r.overflowFlag;
   endproperty
   a_upWrap: assert property (p_upWrap) else $error("no wrap at terminal");

   property p_freeRun;
      tick && !centerAlignSelect && st_r.modulus == tpc_pkg::COUNT_ZERO
         && st_r.count == tpc_pkg::COUNT_MAX |=> st_r.count == tpc_pkg::COUNT_ZERO;
   endproperty
   a_freeRun: assert property (p_freeRun) else $error("free run did not wrap");

   property p_turnDown;
      tick && centerAlignSelect && !st_r.countDown && st_r.modulus != tpc_pkg::COUNT_ZERO
         && st_r.count == st_r.modulus
         |=> st_r.countDown && st_r.overflowFlag && st_r.count == $past(st_r.count) - 16'h0001;
   endproperty
   a_turnDown: assert property (p_turnDown) else $error("no reversal at modulus");

   property p_turnUp;
      tick && centerAlignSelect && st_r.countDown && st_r.count == tpc_pkg::COUNT_ZERO
         |=> !st_r.countDown && st_r.count == tpc_pkg::COUNT_ONE;
   endproperty
   a_turnUp: assert property (p_turnUp) else $error("no turn at zero");

   property p_clockOff;
      clockSourceSelect == tpc_pkg::CLK_OFF && !countWrite [*2] |-> $stable(st_r.count);
   endproperty
   a_clockOff: assert property (p_clockOff) else $error("counted with clock off");

   property p_countClear;
      countWrite |=> st_r.count == tpc_pkg::COUNT_ZERO && !st_r.latched;
   endproperty
   a_countClear: assert property (p_countClear) else $error("count write ignored");

   property p_modDiscard;
      timerControlWrite |=> !st_r.modHiSeen && !st_r.modLoSeen;
   endproperty
   a_modDiscard: assert property (p_modDiscard) else $error("modulus bytes kept");

   property p_setWins;
      timeBase.loadDue && overflowFlagClear |=> st_r.overflowFlag;
   endproperty
   a_setWins: assert property (p_setWins) else $error("overflow lost to clear");

   property p_modLoadTime;
      !$stable(st_r.modulus) |-> $past(timeBase.loadDue);
   endproperty
   a_modLoadTime: assert property (p_modLoadTime) else $error("modulus loaded mid period");

   property p_irqLevel;
      overflowIrqEnable && st_r.overflowFlag |-> overflowIrq;
   endproperty
   a_irqLevel: assert property (p_irqLevel) else $error("irq missing");

   c_reverse: cover property (timeBase.reverse);
   c_flagCleared: cover property (st_r.overflowFlag ##1 overflowFlagRead ##[1:4] !st_r.overflowFlag);
   c_latchedRead: cover property (countReadHigh ##[1:8] countReadLow);

endmodule
`default_nettype wire

/* tb/tpc_pin_source.sv */
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_source (
   // Clock.
   input wire logic clock,
   // Cycles between edges; zero holds the pin at its level.
   input wire logic [7:0] spacing,
   // Pin level.
   output logic pin
);
   logic [7:0] ticks = 8'h00;
   logic level = 1'b0;
   assign pin = level;
   always @(posedge clock)
      if (spacing != 8'h00)
      begin
         ticks <= (ticks + 8'h01 >= spacing) ? 8'h00 : ticks + 8'h01;
         if (ticks == 8'h00)
            level <= !level;
      end
endmodule
`default_nettype wire

/* tb/tpc_timer_pwm_channel_unit_test.sv */
`timescale 1ns/1ps
`default_nettype none
module tpc_timer_pwm_channel_unit_test;
   // ****************************************
   // Stimulus, outputs and model state
   // ****************************************
   logic clock = 1'b0, reset = 1'b1, cas = 1'b0, ovfEn = 1'b0, fixTick = 1'b0, extTick = 1'b0;
   logic tcWr = 1'b0, cntWr = 1'b0, ovfRd = 1'b0, ovfClr = 1'b0, pwmChk = 1'b0, tick, act;
   logic rdHi = 1'b0, rdLo = 1'b0, mLatd, mFirstHi;
   logic [1:0] css = 2'h0, ccWr = 2'h0, chRd = 2'h0, chClr = 2'h0, pinOut, pinOe, chFlag, chIrq;
   wire [1:0] pinIn;
   logic [7:0] spacing = 8'h00, rdByte, mByte;
   logic [15:0] count, modulus;
   logic [15:0] vals [7] = '{16'h0000, 16'h0003, 16'h0006, 16'h0000, 16'h0002, 16'h0007, 16'h8002};
   logic [1:0][15:0] chVal;
   logic ovfFlag, ovfIrq, mDown, mOvf, mArm;
   logic [1:0] seen, vSeen;
   tpc_pkg::tpc_byte_wr_t modWr = '0;
   tpc_pkg::tpc_byte_wr_t [1:0] valWr = '0;
   tpc_pkg::tpc_chan_cfg_t [1:0] cfg = '0;
   int seed = 32'h669e45cb;
   int miscompares = 0, totalChecks = 0, i, n, t, ld, mCnt, mMod, mBuf, mVal, vBuf, mLat;

   always #5 clock = !clock;
   assign pinIn[0] = 1'b0;
   assign tick = css == 2'h1 || (css == 2'h2 && fixTick) || (css == 2'h3 && extTick);

   tpc_pin_source pin_u (.clock(clock), .spacing(spacing), .pin(pinIn[1]));

   tpc_timer_pwm_channel_unit #(.CHANNELS(2)) dut_u (.clock(clock), .reset(reset),
      .clockSourceSelect(css), .centerAlignSelect(cas), .overflowIrqEnable(ovfEn),
      .fixedClockTick(fixTick), .externalClockTick(extTick), .timerControlWrite(tcWr),
      .modulusWrite(modWr), .countWrite(cntWr), .countReadHigh(rdHi), .countReadLow(rdLo),
      .overflowFlagRead(ovfRd), .overflowFlagClear(ovfClr), .chanCfg(cfg),
      .chanControlWrite(ccWr), .chanValueWrite(valWr), .chanFlagRead(chRd),
      .chanFlagClear(chClr), .chanPinIn(pinIn), .chanPinOut(pinOut), .chanPinOe(pinOe),
      .count(count), .modulus(modulus), .countReadByte(rdByte), .overflowFlag(ovfFlag),
      .overflowIrq(ovfIrq), .chanValue(chVal), .chanFlag(chFlag), .chanIrq(chIrq));

   // ****************************************
   // Reference model, one step per clock
   // ****************************************
   always @(posedge clock)
   begin
      fixTick <= 1'($random(seed));
      extTick <= 1'($random(seed));
      if (reset)
         {mCnt, mMod, mBuf, mVal, vBuf, mDown, mOvf, mArm, seen, vSeen, mLat, mLatd, mByte} = '0;
      else
      begin
         ld = 0;
         t = (mMod == 0) ? 'hffff : mMod;
         n = mCnt;
         if (cntWr)
            n = 0;
         else if (tick)
         begin
            ld = cas ? int'(mCnt == mMod) : int'(mCnt == t);
            n = cas ? (((ld != 0) || (mDown && mCnt != 0)) ? mCnt - 1 : mCnt + 1) :
               ((ld != 0) ? 0 : mCnt + 1);
            mDown = n < mCnt;
         end
         // The first byte read freezes the count; the other byte comes from that snapshot.
         if (rdHi || rdLo)
         begin
            mByte = 8'((mLatd ? mLat : mCnt) >> (rdHi ? 8 : 0));
            if (!mLatd)
               {mLat, mLatd, mFirstHi} = {mCnt, 1'b1, rdHi};
            else if (rdHi != mFirstHi)
               mLatd = 1'b0;
         end
         if (cntWr)
            mLatd = 1'b0;
         mCnt = n;
         if (ld != 0)
            {mOvf, mArm} = 2'b10;
         else if (ovfClr && mArm)
            {mOvf, mArm} = 2'b00;
         else if (ovfRd && mOvf)
            mArm = 1'b1;
         if (ld != 0 && seen == 2'h3)
            {mMod, seen} = {mBuf, 2'h0};
         if (vSeen == 2'h3 && (ld != 0 || !(cas || cfg[0].modeSelB)))
            {mVal, vSeen} = {vBuf, 2'h0};
         if (modWr.high) mBuf[15:8] = modWr.data;
         if (modWr.low) mBuf[7:0] = modWr.data;
         if (valWr[0].high) vBuf[15:8] = valWr[0].data;
         if (valWr[0].low) vBuf[7:0] = valWr[0].data;
         seen = tcWr ? 2'h0 : seen | {modWr.high, modWr.low};
         vSeen = ccWr[0] ? 2'h0 : vSeen | {valWr[0].high, valWr[0].low};
      end
   end

   always @(negedge clock)
      if (!reset)
      begin
         act = (!cas || (!mVal[15] && mVal != 0))
            && (mCnt < mVal || (cas && mDown && mCnt == mVal));
         check(count, mCnt[15:0]);
         check(16'(rdByte), 16'(mByte));
         check(modulus, mMod[15:0]);
         check(16'({ovfIrq, ovfFlag}), 16'({mOvf & ovfEn, mOvf}));
         check(chVal[0], mVal[15:0]);
         if (pwmChk)
            check(16'({pinOe[0], pinOut[0]}), 16'({1'b1, act ^ cfg[0].edgeLevelSelectA}));
      end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
      end
   endtask

   task automatic run(input int k);
      repeat (k) @(posedge clock);
   endtask

   task automatic wr(input int ch, input logic hi, input logic [7:0] d);
      @(posedge clock);
      if (ch < 0) modWr <= {d, hi, !hi};
      else valWr[0] <= {d, hi, !hi};
      @(posedge clock);
      modWr <= '0;
      valWr[0] <= '0;
   endtask

   task automatic pulse(input int w);
      @(posedge clock);
      {rdHi, rdLo, tcWr, cntWr, ovfRd, ovfClr, ccWr[0], chRd[1], chClr[1]} <= 9'(1 << w);
      @(posedge clock);
      {rdHi, rdLo, tcWr, cntWr, ovfRd, ovfClr, ccWr[0], chRd[1], chClr[1]} <= '0;
   endtask

   // The pin is judged only after a whole period, since a load edge may mix old and new values.
   task automatic pwmRun(input logic [15:0] v, input logic pol);
      pwmChk = 1'b0;
      cfg[0].edgeLevelSelectA <= pol;
      wr(0, 1'b1, v[15:8]);
      wr(0, 1'b0, v[7:0]);
      run(30);
      pwmChk = 1'b1;
      run(24);
      pwmChk = 1'b0;
   endtask

   task automatic closeOut;
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ****************************************
   // Sequence
   // ****************************************
   initial
   begin
      run(90000);
      miscompares++;
      closeOut();
   end

   initial
   begin
      run(16);
      reset <= 1'b0;
      run(20);
      css <= 2'h1;
      cfg <= {5'b00011, 5'b01011};
      spacing <= 8'h07;
      wr(0, 1'b0, 8'h00);
      pulse(2);
      wr(0, 1'b1, 8'h02);
      run(5);
      wr(0, 1'b0, 8'h00);
      run(1000);
      @(negedge clock);
      check(16'({chIrq[0], chFlag[0]}), 16'h0003);
      check(16'({pinOe[1], pinOut[1], chIrq[1], chFlag[1]}), 16'h0003);
      spacing <= 8'h00;
      run(4);
      pulse(1);
      pulse(0);
      run(2);
      @(negedge clock);
      check(16'(chFlag[1]), 16'h0000);
      wr(-1, 1'b1, 8'h00);
      wr(-1, 1'b0, 8'h05);
      // Split count reads, with a count write dropping a half-read snapshot.
      pulse(7);
      run(9);
      pulse(8);
      pulse(7);
      pulse(5);
      run(9);
      pulse(7);
      for (i = 0; i < 70000 && mMod != 5; i++) @(posedge clock);
      cfg[0] <= 5'b10000;
      for (i = 0; i < 6; i++) pwmRun(vals[i / 2], i[0]);
      ovfEn <= 1'b1;
      for (i = 0; i < 8; i++)
      begin
         while (mCnt != 1) @(posedge clock);
         pulse(4);
         run(($random(seed) & 7) + 1);
         pulse(3);
      end
      pulse(5);
      cas <= 1'b1;
      wr(-1, 1'b0, 8'h04);
      pulse(6);
      wr(-1, 1'b1, 8'h00);
      run(30);
      wr(-1, 1'b0, 8'h04);
      for (i = 0; i < 8; i++) pwmRun(vals[3 + i / 2], i[0]);
      cas <= 1'b0;
      css <= 2'h2;
      run(200);
      css <= 2'h3;
      run(200);
      closeOut();
   end
endmodule
`default_nettype wire
